// File: src/ccp_top.v
// Codec control port: 2/3-wire serial writes, DAC setup registers
// Notes on behaviour
// - Strap pin picks 2-wire (0) or 3-wire (1)
// - 3-wire: data line shifted on serial clock
// - Word: address bits 15:9, data bits 8:0
// - 3-wire commit on select strobe rising edge
// - 2-wire target address chosen by strobe level
// - START then eight bits, address and R/W
// - Matching write address acknowledged low
// - Mismatch or read: no ack, back idle
// - Upper then lower byte, each acknowledged
// - STOP returns idle, stray START restarts address
// - Format bit 5 selects DAC master or slave
// - Master role generates bit and frame clocks
// - Rate field 4:2 decodes six rates
// - Reference 12.288 or 11.2896 MHz by rate
// - Right-justified 32-bit falls back to 24
// - Inactive interface pins tristate, never driven
// - Activation bit 0 enables interface, resets 0
// - Power bit 5 forces power-off, resets 1
// - Power bits 4,3,2 down output, DAC, ADC
// - Format bits 1:0 select justification
`timescale 1ns/100ps
`include "ccp_consts.vh"
module ccp_top #(
  parameter WL = 16
) (
  input wire ref_clk,
  input wire rstn,
  input wire mode_strap,
  input wire serial_clock_line,
  input wire serial_data_line_in,
  output reg serial_data_line_out,
  output reg serial_data_line_oe,
  input wire select_strobe,
  input wire dac_bit_clock_in,
  output reg dac_bit_clock_out,
  output reg dac_bit_clock_oe,
  input wire dac_frame_clock_in,
  output reg dac_frame_clock_out,
  output reg dac_frame_clock_oe,
  output reg dac_role_select,
  output reg [2:0] dac_rate_select,
  output reg [1:0] dac_justify,
  output reg [1:0] dac_word_length,
  output reg ref_clock_select,
  output reg [8:0] fs_ratio,
  output reg iface_active,
  output reg power_off,
  output reg output_stage_down,
  output reg dac_path_down,
  output reg adc_path_down,
  output reg dac_bclk_seen
);
  // Pin synchronisers
  wire [4:0] sy;
  ccp_sync #(.W(5)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in({dac_bit_clock_in, select_strobe, serial_data_line_in, serial_clock_line,
      mode_strap}),
    .sync_out(sy)
  );
  wire mode_s = sy[0];
  wire scl_s = sy[1];
  wire sda_s = sy[2];
  wire csb_s = sy[3];
  wire dbclk_s = sy[4];
  reg scl_q;
  reg sda_q;
  reg csb_q;
  reg dbclk_q;
  reg mode_q;

  // Edge detect history
  always @(posedge ref_clk) begin
    if (!rstn) begin
      scl_q <= 1'b0;
      sda_q <= 1'b1;
      csb_q <= 1'b1;
      dbclk_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      csb_q <= csb_s;
      dbclk_q <= dbclk_s;
      mode_q <= mode_s;
    end
  end
  // Pin edges and bus conditions
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
  wire csb_rise = csb_s & ~csb_q;
  wire three_wire = mode_q;

  // Registers
  reg [8:0] act_q;
  reg [8:0] pwr_q;
  reg [8:0] fmt_q;
  reg [8:0] rate_q;
  // 3-wire shift register
  reg [15:0] sh3_q;
  // 2-wire machine
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_ACKA = 3'h2;
  localparam S_BYTE = 3'h3;
  localparam S_ACKB = 3'h4;
  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg [15:0] sh2_q;
  reg bytes_q;
  reg ack_drv_q;
  reg wr_en;
  reg [15:0] wr_word;
  // Eighth bit of a byte has been clocked in
  wire byte_done = scl_fall && (cnt_q == `CCP_BYTE_BITS);

  // Address match against strobe-selected target
  function addr_ok;
    input [7:0] b;
    input sel;
    begin
      addr_ok = (b[7:1] == {`CCP_ADDR_BASE, sel}) && !b[0];
    end
  endfunction


  // 3-wire shift on serial clock rise
  always @(posedge ref_clk) begin
    if (!rstn) begin
      sh3_q <= 16'h0000;
    end else if (three_wire && scl_rise) begin
      sh3_q <= {sh3_q[14:0], sda_s};
    end
  end


  // 2-wire protocol engine
  always @(posedge ref_clk) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh2_q <= 16'h0000;
      bytes_q <= 1'b0;
      ack_drv_q <= 1'b0;
    end else if (three_wire) begin
      st_q <= S_IDLE;
      ack_drv_q <= 1'b0;
    end else if (start_c) begin
      st_q <= S_ADDR;
      cnt_q <= 4'h0;
      bytes_q <= 1'b0;
      ack_drv_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= S_IDLE;
      ack_drv_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          ack_drv_q <= 1'b0;
        end
        S_ADDR: begin
          if (scl_rise) begin
            sh2_q <= {sh2_q[14:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_done) begin
            cnt_q <= 4'h0;
            if (addr_ok(sh2_q[7:0], csb_s)) begin
              st_q <= S_ACKA;
              ack_drv_q <= 1'b1;
            end else begin
              st_q <= S_IDLE;
            end
          end
        end
        S_ACKA, S_ACKB: begin
          if (scl_fall) begin
            ack_drv_q <= 1'b0;
            if (st_q == S_ACKB && bytes_q) begin
              st_q <= S_IDLE;
            end else begin
              bytes_q <= (st_q == S_ACKB);
              st_q <= S_BYTE;
            end
          end
        end
        S_BYTE: begin
          if (scl_rise) begin
            sh2_q <= {sh2_q[14:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_done) begin
            cnt_q <= 4'h0;
            st_q <= S_ACKB;
            ack_drv_q <= 1'b1;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // Commit strobes for either format
  always @* begin
    wr_en = 1'b0;
    wr_word = sh3_q;
    if (three_wire) begin
      wr_en = csb_rise;
    end else if (st_q == S_BYTE && bytes_q && byte_done) begin
      wr_en = 1'b1;
      wr_word = sh2_q;
    end
  end
  // Address and data fields of the committed word
  wire [6:0] wa = wr_word[`CCP_ADR_HI:`CCP_ADR_LO];
  wire [8:0] wd = wr_word[`CCP_DAT_HI:`CCP_DAT_LO];

  // Register writes
  always @(posedge ref_clk) begin
    if (!rstn) begin
      act_q <= `CCP_RST_ACTIVATE;
      pwr_q <= `CCP_RST_POWER;
      fmt_q <= `CCP_RST_DAC_FMT;
      rate_q <= `CCP_RST_DAC_RATE;
    end else if (wr_en) begin
      case (wa)
        `CCP_REG_ACTIVATE: act_q <= wd;
        `CCP_REG_POWER: pwr_q <= wd;
        `CCP_REG_DAC_FMT: fmt_q <= wd;
        `CCP_REG_DAC_RATE: rate_q <= wd;
        default: act_q <= act_q;
      endcase
    end
  end


  // Rate and word length decode
  reg [8:0] fs_d;
  reg ref_d;
  reg [1:0] wl_d;
  always @* begin
    fs_d = `CCP_FS_256;
    ref_d = 1'b0;
    case (rate_q[`CCP_RATE_HI:`CCP_RATE_LO])
      `CCP_RATE_96K: fs_d = `CCP_FS_128;
      `CCP_RATE_44K1: ref_d = 1'b1;
      `CCP_RATE_88K2: begin
        ref_d = 1'b1;
        fs_d = `CCP_FS_128;
      end
      default: fs_d = `CCP_FS_256;
    endcase
    wl_d = fmt_q[`CCP_IWL_HI:`CCP_IWL_LO];
    if (fmt_q[`CCP_JUST_HI:`CCP_JUST_LO] == `CCP_FMT_RJ &&
      fmt_q[`CCP_IWL_HI:`CCP_IWL_LO] == `CCP_IWL_32) begin
      wl_d = `CCP_IWL_24;
    end
  end


  // Master clock generation: bit clock = ref/8, frame = bclk/(2*WL)
  wire master = fmt_q[`CCP_BIT_ROLE];
  wire act = act_q[`CCP_BIT_ACTIVE];
  reg [1:0] bdiv_q;
  reg [7:0] fdiv_q;
  reg bclk_q;
  reg lrc_q;
  always @(posedge ref_clk) begin
    if (!rstn || !master || !act) begin
      bdiv_q <= 2'h0;
      fdiv_q <= 8'h00;
      bclk_q <= 1'b0;
      lrc_q <= 1'b0;
    end else begin
      bdiv_q <= bdiv_q + 2'h1;
      if (bdiv_q == `CCP_BCLK_TAP) begin
        bclk_q <= ~bclk_q;
        if (bclk_q) begin
          if (fdiv_q == WL[7:0] - 8'h01) begin
            fdiv_q <= 8'h00;
            lrc_q <= ~lrc_q;
          end else begin
            fdiv_q <= fdiv_q + 8'h01;
          end
        end
      end
    end
  end


  // Output registers
  always @(posedge ref_clk) begin
    if (!rstn) begin
      serial_data_line_out <= 1'b0;
      serial_data_line_oe <= 1'b0;
      dac_bit_clock_out <= 1'b0;
      dac_bit_clock_oe <= 1'b0;
      dac_frame_clock_out <= 1'b0;
      dac_frame_clock_oe <= 1'b0;
      dac_role_select <= 1'b0;
      dac_rate_select <= 3'h0;
      dac_justify <= `CCP_RST_JUSTIFY;
      dac_word_length <= `CCP_RST_WLEN;
      ref_clock_select <= 1'b0;
      fs_ratio <= `CCP_FS_256;
      iface_active <= 1'b0;
      power_off <= 1'b1;
      output_stage_down <= 1'b1;
      dac_path_down <= 1'b1;
      adc_path_down <= 1'b1;
      dac_bclk_seen <= 1'b0;
    end else begin
      serial_data_line_out <= 1'b0;
      serial_data_line_oe <= ack_drv_q;
      dac_bit_clock_out <= bclk_q;
      dac_bit_clock_oe <= master & act;
      dac_frame_clock_out <= lrc_q;
      dac_frame_clock_oe <= master & act;
      dac_role_select <= master;
      dac_rate_select <= rate_q[`CCP_RATE_HI:`CCP_RATE_LO];
      dac_justify <= fmt_q[`CCP_JUST_HI:`CCP_JUST_LO];
      dac_word_length <= wl_d;
      ref_clock_select <= ref_d;
      fs_ratio <= fs_d;
      iface_active <= act;
      power_off <= pwr_q[`CCP_BIT_POWEROFF];
      output_stage_down <= pwr_q[`CCP_BIT_OUTPUT_STAGE_DOWN];
      dac_path_down <= pwr_q[`CCP_BIT_DAC_PATH_DOWN];
      adc_path_down <= pwr_q[`CCP_BIT_ADC_PATH_DOWN];
      dac_bclk_seen <= ~master & act & dbclk_s & ~dbclk_q;
    end
  end
endmodule // ccp_top

// File: inc/ccp_consts.vh
// Constants for the codec control port and DAC setup block
`ifndef CCP_CONSTS_VH
`define CCP_CONSTS_VH
`define CCP_REG_ACTIVATE 7'h09
`define CCP_REG_POWER 7'h12
`define CCP_REG_DAC_FMT 7'h13
`define CCP_REG_DAC_RATE 7'h14
`define CCP_ADDR_BASE 6'h0D
`define CCP_WORD_BITS 5'h10
`define CCP_ADR_HI 15
`define CCP_ADR_LO 9
`define CCP_BIT_ROLE 5
`define CCP_BIT_ACTIVE 0
`define CCP_BIT_POWEROFF 5
`define CCP_BIT_OUTPUT_STAGE_DOWN 4
`define CCP_BIT_DAC_PATH_DOWN 3
`define CCP_BIT_ADC_PATH_DOWN 2
`define CCP_RST_ACTIVATE 9'h000
`define CCP_RST_POWER 9'h03F
`define CCP_RST_DAC_FMT 9'h00A
`define CCP_RST_DAC_RATE 9'h000
`define CCP_FMT_RJ 2'h0
`define CCP_IWL_32 2'h3
`define CCP_IWL_24 2'h2
`define CCP_RATE_48K 3'h0
`define CCP_RATE_8K 3'h1
`define CCP_RATE_32K 3'h2
`define CCP_RATE_96K 3'h3
`define CCP_RATE_44K1 3'h4
`define CCP_RATE_88K2 3'h5
`define CCP_FS_256 9'h100
`define CCP_FS_128 9'h080
`define CCP_BYTE_BITS 4'h8
`define CCP_BCLK_TAP 2'h1
`define CCP_DAT_HI 8
`define CCP_DAT_LO 0
`define CCP_JUST_HI 1
`define CCP_JUST_LO 0
`define CCP_IWL_HI 3
`define CCP_IWL_LO 2
`define CCP_RATE_HI 4
`define CCP_RATE_LO 2
`define CCP_RST_JUSTIFY 2'h2
`define CCP_RST_WLEN 2'h2
`endif

// File: src/ccp_sync.v
// Two-stage synchroniser for pins entering the ref_clk domain
`timescale 1ns/100ps
module ccp_sync #(
  parameter W = 4
) (
  input wire ref_clk,
  input wire rstn,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  // First stage read only by second stage
  always @(posedge ref_clk) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // ccp_sync

// File: tb/ccp_host_model.sv
// Host microcontroller model driving the serial control port
`timescale 1ns/100ps
module ccp_host_model (
  input wire ref_clk,
  input wire sda,
  output reg scl,
  output reg sda_drv,
  output reg strobe
);
  // Idle: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    strobe = 1'b0;
  end
  // Select strobe level
  task set_sel(input b);
    strobe = b;
  endtask
  // One bit: data set while clock low, 40 ns clock pulse
  task bit_out(input b);
    begin
      sda_drv = b;
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
    end
  endtask
  // Addressed write: START, three bytes with ack samples, STOP
  task w2(input [7:0] a, input [15:0] w, output [2:0] ack);
    reg [23:0] s;
    integer i;
    begin
      s = {a, w};
      @(negedge ref_clk);
      sda_drv = 1'b0;
      #40 scl = 1'b0;
      #20;
      for (i = 0; i < 24; i = i + 1) begin
        bit_out(s[23-i]);
        if (i % 8 == 7) begin
          sda_drv = 1'b1;
          #20 scl = 1'b1;
          #20 ack[2-i/8] = ~sda;
          #20 scl = 1'b0;
          #20;
        end
      end
      sda_drv = 1'b0;
      #20 scl = 1'b1;
      #20 sda_drv = 1'b1;
      #80;
    end
  endtask
  // Strobe-latched write: 16 bits MSB first, then strobe rise
  task w3(input [15:0] w);
    integer i;
    begin
      @(negedge ref_clk);
      strobe = 1'b0;
      scl = 1'b0;
      #20;
      for (i = 15; i >= 0; i = i - 1)
        bit_out(w[i]);
      sda_drv = 1'b1;
      strobe = 1'b1;
      #40 scl = 1'b1;
      #80;
    end
  endtask
endmodule // ccp_host_model

// File: tb/ccp_top_chk.sv
// Concurrent checks on the control port and DAC setup outputs
`timescale 1ns/100ps
module ccp_top_chk (
  input wire ref_clk,
  input wire rstn,
  input wire mode_strap,
  input wire serial_data_line_out,
  input wire serial_data_line_oe,
  input wire dac_bit_clock_oe,
  input wire dac_role_select,
  input wire iface_active,
  input wire [2:0] dac_rate_select,
  input wire [1:0] dac_justify,
  input wire [1:0] dac_word_length,
  input wire ref_clock_select,
  input wire [8:0] fs_ratio,
  input wire dac_bclk_seen
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  bco_role_a: assert property (dac_bit_clock_oe |-> dac_role_select && iface_active)
    else $error("bit clock driven off role");
  ack_low_a: assert property (serial_data_line_oe |-> !serial_data_line_out)
    else $error("ack not low");
  ack_hold_a: assert property ($rose(serial_data_line_oe) |-> serial_data_line_oe[*4])
    else $error("ack too short");
  strap_quiet_a: assert property (mode_strap[*6] |-> !serial_data_line_oe)
    else $error("ack in 3-wire");
  rj_width_a: assert property (!(dac_justify == 2'h0 && dac_word_length == 2'h3))
    else $error("RJ 32 bit kept");
  ref_sel_a: assert property ($stable(dac_rate_select)[*3] |->
    ref_clock_select == (dac_rate_select == 3'h4 || dac_rate_select == 3'h5))
    else $error("ref select wrong");
  fs_sel_a: assert property ($stable(dac_rate_select)[*3] |-> fs_ratio ==
    ((dac_rate_select == 3'h3 || dac_rate_select == 3'h5) ? 9'h080 : 9'h100))
    else $error("fs ratio wrong");
  seen_slave_a: assert property (dac_bclk_seen |-> !dac_role_select && iface_active)
    else $error("bit clock seen off role");
  // Main scenarios
  cover property ($rose(serial_data_line_oe));
  cover property (dac_bclk_seen);
  cover property (dac_bit_clock_oe);
endmodule // ccp_top_chk

bind ccp_top ccp_top_chk chk_i (.ref_clk(ref_clk), .rstn(rstn), .mode_strap(mode_strap),
  .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
  .dac_bit_clock_oe(dac_bit_clock_oe), .dac_role_select(dac_role_select),
  .iface_active(iface_active), .dac_rate_select(dac_rate_select), .dac_justify(dac_justify),
  .dac_word_length(dac_word_length), .ref_clock_select(ref_clock_select),
  .fs_ratio(fs_ratio), .dac_bclk_seen(dac_bclk_seen));

// File: tb/test_ccp_top.sv
// Self-checking bench for the codec control port
`timescale 1ns/100ps
module test_ccp_top;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg mode_strap = 1'b0;
  reg bclk = 1'b0;
  wire scl, sda_drv, strobe, sdo, soe, sda, bco, bcoe, fco, fcoe, role, rsel;
  wire act, poff, opd, dpd, apd, seen;
  wire [2:0] rate;
  wire [1:0] just, wl;
  wire [8:0] fs;
  reg [2:0] ack;
  integer err_total = 0;
  integer checks = 0;
  integer i, n;
  // Clocks, open-drain data line with pull-up
  always #5 ref_clk = ~ref_clk;
  always #40 bclk = ~bclk;
  assign sda = sda_drv & ~(soe & ~sdo);
  ccp_host_model host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv),
    .strobe(strobe));
  ccp_top dut (.ref_clk(ref_clk), .rstn(rstn), .mode_strap(mode_strap),
    .serial_clock_line(scl), .serial_data_line_in(sda), .serial_data_line_out(sdo),
    .serial_data_line_oe(soe), .select_strobe(strobe), .dac_bit_clock_in(bclk),
    .dac_bit_clock_out(bco), .dac_bit_clock_oe(bcoe), .dac_frame_clock_in(1'b0),
    .dac_frame_clock_out(fco), .dac_frame_clock_oe(fcoe), .dac_role_select(role),
    .dac_rate_select(rate), .dac_justify(just), .dac_word_length(wl),
    .ref_clock_select(rsel), .fs_ratio(fs), .iface_active(act), .power_off(poff),
    .output_stage_down(opd), .dac_path_down(dpd), .adc_path_down(apd), .dac_bclk_seen(seen));
  // Compare and count
  task chk(input [8:0] sv, input [8:0] ev);
    begin
      checks = checks + 1;
      if (sv !== ev) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, sv, ev);
      end
    end
  endtask
  // Verdict and end of run
  task report_and_stop;
    begin
      if (err_total == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({poff, opd, dpd, apd, act, role}, 9'h03C);
    chk({rate, just, wl}, 9'h00A);
    host.w2(8'h34, {7'h12, 9'h000}, ack);
    chk({ack, poff, opd, dpd, apd}, 9'h070);
    host.set_sel(1'b1);
    host.w2(8'h34, {7'h12, 9'h03C}, ack);
    chk({ack, poff}, 9'h000);
    host.w2(8'h37, {7'h12, 9'h03C}, ack);
    chk({ack, poff}, 9'h000);
    host.w2(8'h36, {7'h13, 9'h00C}, ack);
    chk({ack, just, wl}, 9'h072);
    for (i = 0; i < 6; i = i + 1) begin
      host.w2(8'h36, {7'h14, 3'h0, i[3:0], 2'h0}, ack);
      chk({rate, rsel}, {i[2:0], i > 3});
      chk(fs, (i == 3 || i == 5) ? 9'h080 : 9'h100);
    end
    mode_strap = 1'b1;
    host.w3({7'h13, 9'h020});
    chk({role, bcoe, fcoe}, 9'h004);
    host.w2(8'h36, {7'h12, 9'h03C}, ack);
    chk({ack, poff}, 9'h000);
    host.w3({7'h09, 9'h001});
    repeat (20) @(negedge ref_clk);
    chk({act, bcoe, fcoe}, 9'h007);
    // Master clocks: half of any 256-cycle window high
    n = 0;
    i = 0;
    repeat (256) @(negedge ref_clk) begin
      n = n + bco;
      i = i + fco;
    end
    chk(n[8:0], 9'h080);
    chk(i[8:0], 9'h080);
    host.w3({7'h09, 9'h000});
    chk({act, bcoe, fcoe}, 9'h000);
    host.w3({7'h13, 9'h000});
    host.w3({7'h09, 9'h001});
    n = 0;
    repeat (200) @(negedge ref_clk) n = n + seen;
    chk({role, bcoe, n >= 20}, 9'h001);
    // Mid-run reset restores register defaults
    rstn = 1'b0;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({poff, opd, dpd, apd, act, role}, 9'h03C);
    report_and_stop;
  end
  // Watchdog
  initial begin
    #200000;
    err_total = err_total + 1;
    report_and_stop;
  end
endmodule // test_ccp_top
